// >>> design/uab_core.sv
// Auto-baud overflow handling and wake-on-break core of the serial receiver
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module uab_core
  import uab_pkg::*;
#(
  parameter int unsigned CNT_W = uab_pkg::DIV_W
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic                       receive_line_pin,
  input  wire logic [uab_pkg::ADDR_W-1:0] addr,
  input  wire logic [uab_pkg::DATA_W-1:0] wdata,
  input  wire logic                       wr_stb,
  input  wire logic                       rd_stb,
  output var  logic [uab_pkg::DATA_W-1:0] rdata,
  output var  logic                       irq,
  output var  logic                       receive_int_flag,
  output var  logic                       receive_idle_flag,
  output var  logic                       start_bit_pulse
);
  import uab_pkg::*;

  logic rx_s;
  logic rx_rise;
  logic rx_fall;
  uab_state_t state_r;
  uab_state_t state_nxt;
  logic autobaud_enable_r;
  logic wake_on_break_enable_r;
  logic autobaud_overflow_flag_r;
  logic async_mode_r;
  logic sleep_r;
  logic rxen_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] baud_divisor_pair_r;
  logic [3:0] edges_r;
  logic rxint_ovf_r;
  logic rxint_wake_r;
  logic rxint_rearm_r;
  logic receive_done_flag_r;
  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] mask_r;

  uab_sync u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .din     (receive_line_pin),
    .dout    (rx_s)
  );

  uab_edge u_edge (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .level   (rx_s),
    .rise    (rx_rise),
    .fall    (rx_fall)
  );

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] reg_a, input logic stb);
    hit = stb && (a == reg_a);
  endfunction

  wire wr_ctrl    = hit(addr, ADDR_CTRL, wr_stb);
  wire wr_mask    = hit(addr, ADDR_MASK, wr_stb);
  wire rd_status  = hit(addr, ADDR_STATUS, rd_stb);
  wire rd_data    = hit(addr, ADDR_DATA, rd_stb);
  wire cnt_max    = &cnt_r;
  wire in_abd     = (state_r == UAB_ABD);
  wire fifth_rise = in_abd && rx_rise && (edges_r == ABD_EDGES - 4'h1);
  wire ovf_event  = in_abd && cnt_max && !autobaud_overflow_flag_r;
  // Sleep has no baud clock, so only the wake monitor may run then
  wire wake_ok    = wake_on_break_enable_r && async_mode_r;
  wire wake_event = (state_r == UAB_WAKE) && rx_fall;
  wire break_end  = (state_r == UAB_BREAK) && rx_rise;
  wire abd_start  = autobaud_enable_r && !wake_ok && !sleep_r && (state_r == UAB_IDLE) && rx_fall;
  wire abd_quit   = in_abd && !autobaud_enable_r;
  wire rearm_hit  = fifth_rise && rxint_rearm_r;
  wire [EV_W-1:0] ev_vec = {fifth_rise, wake_event, ovf_event, ovf_event | wake_event | rearm_hit};
  wire [DATA_W-1:0] ctrl_view = {9'h000, rxen_r, (state_r == UAB_IDLE) && !in_abd, sleep_r,
                                 async_mode_r, autobaud_overflow_flag_r, wake_on_break_enable_r,
                                 autobaud_enable_r};

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      UAB_IDLE: begin
        if (wake_ok)        state_nxt = UAB_WAKE;
        else if (abd_start) state_nxt = UAB_ABD;
      end
      UAB_ABD: begin
        if (fifth_rise || abd_quit) state_nxt = UAB_IDLE;
      end
      UAB_WAKE: begin
        if (!wake_ok)        state_nxt = UAB_IDLE;
        else if (wake_event) state_nxt = UAB_BREAK;
      end
      UAB_BREAK: begin
        if (break_end) state_nxt = UAB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) state_r <= UAB_IDLE;
    else        state_r <= state_nxt;
  end

  // Counter saturates at all ones; past that the overflow flag carries it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_r   <= '0;
      edges_r <= '0;
    end else if (abd_start) begin
      cnt_r   <= '0;
      edges_r <= '0;
    end else if (in_abd) begin
      if (!cnt_max) cnt_r <= cnt_r + 1'b1;
      if (rx_rise)  edges_r <= edges_r + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) baud_divisor_pair_r <= '0;
    else if (fifth_rise && !autobaud_overflow_flag_r) baud_divisor_pair_r <= cnt_r;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      autobaud_enable_r      <= CTRL_RESET[CTRL_ABD];
      wake_on_break_enable_r <= CTRL_RESET[CTRL_WAKE];
      async_mode_r           <= CTRL_RESET[CTRL_ASYNC];
      sleep_r                <= CTRL_RESET[CTRL_SLEEP];
      rxen_r                 <= CTRL_RESET[CTRL_RXEN];
    end else begin
      if (wr_ctrl) begin
        async_mode_r <= wdata[CTRL_ASYNC];
        sleep_r      <= wdata[CTRL_SLEEP];
        rxen_r       <= wdata[CTRL_RXEN];
      end
      if (fifth_rise)   autobaud_enable_r <= 1'b0;
      else if (wr_ctrl) autobaud_enable_r <= wdata[CTRL_ABD];
      if (break_end)    wake_on_break_enable_r <= 1'b0;
      else if (wr_ctrl) wake_on_break_enable_r <= wdata[CTRL_WAKE];
    end
  end

  // Set wins over the software clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n)                                  autobaud_overflow_flag_r <= 1'b0;
    else if (ovf_event)                          autobaud_overflow_flag_r <= 1'b1;
    else if (wr_ctrl && !wdata[CTRL_OVF])        autobaud_overflow_flag_r <= 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxint_ovf_r   <= 1'b0;
      rxint_wake_r  <= 1'b0;
      rxint_rearm_r <= 1'b0;
    end else begin
      rxint_ovf_r   <= ovf_event | rearm_hit | (rxint_ovf_r & ~rd_data);
      rxint_wake_r  <= wake_event | (rxint_wake_r & ~rd_data);
      rxint_rearm_r <= (in_abd && autobaud_overflow_flag_r && rd_data) |
                       (rxint_rearm_r & in_abd & ~fifth_rise);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) receive_done_flag_r <= 1'b0;
    else        receive_done_flag_r <= fifth_rise | (receive_done_flag_r & ~rd_data);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_r <= '0;
      mask_r   <= '0;
    end else begin
      status_r <= ev_vec | (status_r & ~{EV_W{rd_status}});
      if (wr_mask) mask_r <= wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rdata             <= ZERO_WORD;
      irq               <= 1'b0;
      receive_int_flag  <= 1'b0;
      receive_idle_flag <= 1'b1;
      start_bit_pulse   <= 1'b0;
    end else begin
      unique case (1'b1)
        hit(addr, ADDR_CTRL, rd_stb):   rdata <= ctrl_view;
        rd_status:                      rdata <= {{(DATA_W-EV_W){1'b0}}, status_r};
        hit(addr, ADDR_MASK, rd_stb):   rdata <= {{(DATA_W-EV_W){1'b0}}, mask_r};
        rd_data:                        rdata <= ZERO_WORD;
        hit(addr, ADDR_DIV, rd_stb):    rdata <= baud_divisor_pair_r;
        hit(addr, ADDR_EVENTS, rd_stb): rdata <= {12'h000, receive_done_flag_r, rxint_rearm_r,
                                                  rxint_wake_r, rxint_ovf_r};
        default:                        rdata <= ZERO_WORD;
      endcase
      irq               <= |((ev_vec | (status_r & ~{EV_W{rd_status}})) & mask_r);
      receive_int_flag  <= (ovf_event | rearm_hit | wake_event) |
                           ((rxint_ovf_r | rxint_wake_r) & ~rd_data);
      receive_idle_flag <= (state_nxt != UAB_ABD) && (state_nxt != UAB_BREAK);
      // Without auto-baud or wake, a fall is a start bit for the receiver
      start_bit_pulse   <= rx_fall && rxen_r && !sleep_r && !wake_ok &&
                           (state_r == UAB_IDLE) && !autobaud_enable_r;
    end
  end

  a_ovf_sets_int: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovf_event |=> receive_int_flag && autobaud_overflow_flag_r)
    else $error("overflow did not raise interrupt");
  a_ovf_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
    autobaud_overflow_flag_r && !(wr_ctrl && !wdata[CTRL_OVF]) |=> autobaud_overflow_flag_r)
    else $error("overflow flag cleared without write");
  a_idle_in_abd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    in_abd && !fifth_rise && !abd_quit |=> !receive_idle_flag)
    else $error("idle flag high during detection");
  a_idle_at_fifth: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fifth_rise |=> receive_idle_flag)
    else $error("idle flag not set at fifth rise");
  a_rearm_fifth: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fifth_rise && rxint_rearm_r |=> receive_int_flag)
    else $error("fifth rise did not re-raise interrupt");
  a_wake_int: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wake_event |=> receive_int_flag ##0 (state_r == UAB_BREAK))
    else $error("wake event without interrupt");
  a_break_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
    break_end |=> !wake_on_break_enable_r ##1 (state_r == UAB_IDLE))
    else $error("wake enable not cleared at break end");
  a_wake_async_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !async_mode_r && (state_r == UAB_IDLE) |=> state_r != UAB_WAKE)
    else $error("wake armed outside asynchronous mode");
  a_wake_no_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wake_ok |=> !start_bit_pulse)
    else $error("start bit seen while wake enabled");
  a_counter_runs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    in_abd && !cnt_max && !abd_start |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("measurement counter stalled");
  a_data_rd_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_data && !ovf_event && !rearm_hit && !wake_event |=> !receive_int_flag)
    else $error("data read did not clear interrupt");
  a_sleep_no_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sleep_r |=> !start_bit_pulse)
    else $error("start bit seen in sleep");
  a_abd_quit_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    abd_quit |=> state_r == UAB_IDLE)
    else $error("detection not left on enable clear");
  a_fifth_ends_abd: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fifth_rise |=> !autobaud_enable_r && !in_abd)
    else $error("detection not ended at fifth rise");
endmodule
`default_nettype wire

// >>> design/uab_pkg.sv
// Package: register map, field positions and state codes of the auto-baud / wake block
package uab_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_DATA   = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_DIV    = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_EVENTS = 4'h5;
  localparam int unsigned CTRL_ABD   = 0;
  localparam int unsigned CTRL_WAKE  = 1;
  localparam int unsigned CTRL_OVF   = 2;
  localparam int unsigned CTRL_ASYNC = 3;
  localparam int unsigned CTRL_SLEEP = 4;
  localparam int unsigned CTRL_IDLE  = 5;
  localparam int unsigned CTRL_RXEN  = 6;
  localparam int unsigned EV_W     = 4;
  localparam int unsigned EV_RXINT = 0;
  localparam int unsigned EV_OVF   = 1;
  localparam int unsigned EV_WAKE  = 2;
  localparam int unsigned EV_DONE  = 3;
  localparam logic [7:0] CTRL_RESET = 8'h08;
  localparam logic [3:0] ABD_EDGES = 4'h5;
  localparam int unsigned DIV_W = 16;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  typedef enum logic [3:0] {
    UAB_IDLE  = 4'b0001,
    UAB_ABD   = 4'b0010,
    UAB_WAKE  = 4'b0100,
    UAB_BREAK = 4'b1000
  } uab_state_t;
endpackage

// >>> design/uab_sync.sv
// Two-flop synchroniser for the receive line pin
`timescale 1ns/1ns
`default_nettype none
module uab_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic din,
  output var  logic dout
);
  logic meta_r;
  // Idle high line, so the chain resets to one to avoid a false falling edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule
`default_nettype wire

// >>> design/uab_edge.sv
// Rising and falling edge detector on a synchronised level
`timescale 1ns/1ns
`default_nettype none
module uab_edge (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic level,
  output var  logic rise,
  output var  logic fall
);
  logic prev_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) prev_r <= 1'b1;
    else        prev_r <= level;
  end
  assign rise = level & ~prev_r;
  assign fall = ~level & prev_r;
endmodule
`default_nettype wire

// >>> dv/uab_line_model.sv
// Remote serial node model driving the receive line
`timescale 1ns/1ns
`default_nettype none
module uab_line_model (
  output var logic line
);
  logic clk_ref;
  assign clk_ref = testbench.sys_clk;
  initial line = 1'b1;
  task automatic hold(input logic lvl, input int n);
    line <= lvl;
    repeat (n) @(posedge clk_ref);
  endtask
  task automatic send_break(input int bt);
    hold(1'b0, 13 * bt);
    line <= 1'b1;
  endtask
  // Sync character 0x55; a long final low lets the count run past its range
  task automatic send_sync(input int bt, input int last_low);
    hold(1'b0, bt);
    for (int i = 0; i < 4; i++) begin
      hold(1'b1, bt);
      hold(1'b0, (i == 3) ? last_low : bt);
    end
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking testbench of the auto-baud and wake-on-break core
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import uab_pkg::*;
  logic        sys_clk;
  logic        rst_n;
  logic        rx_line;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr_stb;
  logic        rd_stb;
  logic [15:0] rdata;
  logic        irq;
  logic        receive_int_flag;
  logic        receive_idle_flag;
  logic        start_bit_pulse;
  logic        rd_d = 1'b0;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic [15:0] mon_e;
  logic [15:0] mon_m;
  logic [15:0] rnd;
  int          miscompares;
  int          total_checks;
  int          pulse_cnt = 0;
  int          pulse_base;
  int          bt;

  uab_core uab_core_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .receive_line_pin(rx_line), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .irq(irq), .receive_int_flag(receive_int_flag),
    .receive_idle_flag(receive_idle_flag), .start_bit_pulse(start_bit_pulse)
  );
  uab_line_model uab_line_model_inst (.line(rx_line));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a; wdata <= d; wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask
  // Expected word and compare mask go on the queues; the monitor pops them
  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge sys_clk);
    addr <= a; rd_stb <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge sys_clk);
    rd_stb <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // sel 0: interrupt flag rises; sel 1: idle flag drops
  task automatic wait_hi(input int sel, input int bound);
    int n;
    for (n = 0; n < bound; n++) begin
      @(negedge sys_clk);
      if (sel == 0 ? receive_int_flag === 1'b1 : receive_idle_flag === 1'b0) break;
    end
    if (n == bound) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, 16'h0000, 16'h0001);
      final_report();
    end
  endtask

  always @(posedge sys_clk) rd_d <= rd_stb;
  always @(posedge sys_clk) if (start_bit_pulse === 1'b1) pulse_cnt <= pulse_cnt + 1;
  always @(negedge sys_clk) begin
    if (rd_d === 1'b1 && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      mon_m = msk_q.pop_front();
      chk(rdata & mon_m, mon_e & mon_m);
    end
  end

  initial begin
    void'($urandom(32'ha8b7));
    rst_n = 1'b0; addr = 4'h0; wdata = 16'h0000; wr_stb = 1'b0; rd_stb = 1'b0;
    miscompares = 0; total_checks = 0; pulse_base = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, 16'h0008, 16'h005F);
    rnd = 16'($urandom());
    bt = 8 + int'($urandom_range(15));
    wr(4'hF, rnd);
    rd(4'hF, ZERO_WORD, 16'hFFFF);
    wr(ADDR_MASK, rnd);
    rd(ADDR_MASK, rnd & 16'h000F, 16'h000F);
    wr(ADDR_MASK, 16'h0004);
    for (int k = 0; k < 2; k++) begin
      settle(1);
      chkb(receive_idle_flag, 1'b1);
      wr(ADDR_CTRL, 16'h000A);
      fork
        if (k == 0) uab_line_model_inst.send_break(bt);
        else uab_line_model_inst.send_sync(bt, bt);
      join_none
      wait_hi(0, 40);
      settle(2);
      chkb(receive_idle_flag, 1'b0);
      chkb(irq, 1'b1);
      wait fork;
      settle(8);
      rd(ADDR_CTRL, 16'h0008, 16'h000B);
      chkb(receive_idle_flag, 1'b1);
      rd(ADDR_DATA, ZERO_WORD, 16'hFFFF);
      settle(2);
      chkb(receive_int_flag, 1'b0);
      rd(ADDR_STATUS, 16'h0004, 16'h0004);
      settle(2);
      chkb(irq, 1'b0);
    end
    // Wake armed outside asynchronous mode must stay deaf to the break
    wr(ADDR_CTRL, 16'h0002);
    uab_line_model_inst.send_break(bt);
    settle(4);
    chkb(receive_int_flag, 1'b0);
    rd(ADDR_STATUS, ZERO_WORD, 16'h0004);
    pulse_base = pulse_cnt;
    wr(ADDR_CTRL, 16'h0058);
    uab_line_model_inst.send_sync(bt, bt);
    settle(4);
    chk(16'(pulse_cnt - pulse_base), 16'h0000);
    wr(ADDR_CTRL, 16'h0049);
    fork uab_line_model_inst.send_sync(40, 40); join_none
    wait_hi(1, 20);
    repeat (40) @(posedge sys_clk);
    wr(ADDR_CTRL, 16'h0048);
    wait fork;
    settle(4);
    chk(16'(pulse_cnt - pulse_base), 16'h0004);
    wr(ADDR_CTRL, 16'h0009);
    rd(ADDR_STATUS, ZERO_WORD, ZERO_WORD);
    fork uab_line_model_inst.send_sync(bt, bt); join_none
    wait_hi(1, 20);
    wait fork;
    settle(4);
    chkb(receive_idle_flag, 1'b1);
    rd(ADDR_CTRL, 16'h0008, 16'h0007);
    rd(ADDR_STATUS, 16'h0008, 16'h000A);
    wr(ADDR_CTRL, 16'h0009);
    fork uab_line_model_inst.send_sync(bt, 66000); join_none
    wait_hi(0, 70000);
    settle(1);
    chkb(receive_idle_flag, 1'b0);
    rd(ADDR_CTRL, 16'h0005, 16'h0005);
    rd(ADDR_DATA, ZERO_WORD, 16'hFFFF);
    settle(2);
    chkb(receive_int_flag, 1'b0);
    wait_hi(0, 2000);
    settle(1);
    chkb(receive_idle_flag, 1'b1);
    wait fork;
    rd(ADDR_STATUS, 16'h000A, 16'h000A);
    rd(ADDR_DATA, ZERO_WORD, 16'hFFFF);
    rd(ADDR_CTRL, 16'h0004, 16'h0005);
    wr(ADDR_CTRL, 16'h000C);
    rd(ADDR_CTRL, 16'h0004, 16'h0004);
    wr(ADDR_CTRL, 16'h0008);
    rd(ADDR_CTRL, 16'h0008, 16'h0007);
    settle(2);
    final_report();
  end
endmodule
`default_nettype wire
